// ==== hw/asrl_consts.vh ====
// Alarm setpoint relay constants.
// Definitions only.
`ifndef ASRL_CONSTS_VH
`define ASRL_CONSTS_VH

// Channel and relay counts
`define ASRL_NCH             7
`define ASRL_NRELAY          7

// Global register byte offsets
`define ASRL_THR_EN          12'h000
`define ASRL_STATUS          12'h004
`define ASRL_IRQ_STATUS      12'h008
`define ASRL_IRQ_CLEAR       12'h00C
`define ASRL_IRQ_ENABLE      12'h010
`define ASRL_RELAY_STATE     12'h014
`define ASRL_MEAS            12'h018

// Per-channel block: haddr[11:8] region, haddr[7:5] channel, haddr[4:2] field
`define ASRL_CH_REGION       4'h1
`define ASRL_CH_HIGH         3'h0
`define ASRL_CH_LOW          3'h1
`define ASRL_CH_DEADBAND     3'h2
`define ASRL_CH_TRIP         3'h3
`define ASRL_CH_RELEASE      3'h4
`define ASRL_CH_ALLOC        3'h5

// Per-relay control block: haddr[11:8] region, haddr[6:4] relay, haddr[3:2] field
`define ASRL_PI_REGION       4'h2
`define ASRL_PI_SPAN         2'h0
`define ASRL_PI_TARGET       2'h1
`define ASRL_PI_PGAIN        2'h2
`define ASRL_PI_IGAIN        2'h3
`define ASRL_PI_WORDS        28
`define ASRL_BAD_INDEX       3'h7

// Reset values and limits
`define ASRL_THR_EN_RST      16'h0000
`define ASRL_DEADBAND_RST    32'h0000000A
`define ASRL_DEADBAND_MAX    32'h0000C350
`define ASRL_DELAY_RST       16'h0000
`define ASRL_DELAY_MAX       16'hC350
`define ASRL_ALLOC_RST       7'h01
`define ASRL_SPAN_RST        32'h00000064
`define ASRL_TARGET_RST      32'h000003E8
`define ASRL_PGAIN_RST       32'h0000000A
`define ASRL_IGAIN_RST       32'h00000000
`define ASRL_GAIN_MAX        32'h00007FFF

// Timing: delays count in ticks of a tenth of a second
`define ASRL_CLK_HZ          40000000
`define ASRL_TICK_MS         100
`define ASRL_TICK_CYCLES     (`ASRL_CLK_HZ / 1000 * `ASRL_TICK_MS)
`define ASRL_FLASH_TICKS     4'h5

`endif

// ==== hw/asrl_pi_mem.v ====
// Per-relay control parameter storage.
// Assumes the caller clamps write data and only reads indices below the depth.
`timescale 1ns/1ps
`include "asrl_consts.vh"

module asrl_pi_mem (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Write port
   input  wire        we,
   input  wire [4:0]  waddr,
   input  wire [31:0] wdata,
   // Read port, data one cycle after the request
   input  wire        re,
   input  wire [4:0]  raddr,
   output reg  [31:0] rdata
);

   reg     [31:0] mem [0:`ASRL_PI_WORDS-1];
   integer        i;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < `ASRL_PI_WORDS; i = i + 1) begin
            case (i % 4)
               0:       mem[i] <= `ASRL_SPAN_RST;
               1:       mem[i] <= `ASRL_TARGET_RST;
               2:       mem[i] <= `ASRL_PGAIN_RST;
               default: mem[i] <= `ASRL_IGAIN_RST;
            endcase
         end
         rdata <= 32'h00000000;
      end else begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         // Write-first so a read right behind a write sees the new word
         if (re) begin
            if (we && (waddr == raddr)) begin
               rdata <= wdata;
            end else begin
               rdata <= mem[raddr];
            end
         end
      end
   end

endmodule

// ==== hw/asrl_top.v ====
// Alarm setpoint relay logic: seven alarm channels, relay
// allocation and per-relay control parameters.
// Assumes an AHB-Lite master on hclk, a measurement strobe from logic on hclk and a raw
// acknowledge push button pin.
//
// Overview of operation
// - High alarm when measurement at or above
// - Low alarm when measurement at or below
// - Thresholds default disabled, reported as off
// - Both enabled, normal order: alarm outside band
// - High below low: alarm inside band
// - Annunciator flashes until acknowledged, then steady
// - One deadband per channel, 0-50000, default 10
// - High clears below high minus deadband
// - Low clears above low plus deadband
// - Deadband in display units, added directly
// - Trip delay must elapse uninterrupted first
// - Condition lost during trip restarts timer
// - Release delay holds alarm after clearing
// - Condition back during release restarts timer
// - Allocated relays follow channel alarm
// - Per relay span 100, target 1000
// - Per relay gains 0.010, 0.000, max 32.767
`timescale 1ns/1ps
`include "asrl_consts.vh"

module asrl_top #(
   parameter TICK_CYCLES = `ASRL_TICK_CYCLES
) (
   // AHB-Lite clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // Measurement
   input  wire [31:0] meas_value,
   input  wire        meas_strobe,
   // Front panel
   input  wire        ack_button,
   output reg  [6:0]  annunciator,
   // Relays and interrupt
   output reg  [6:0]  relay_out,
   output reg         irq
);

   localparam ST_IDLE    = 4'b0001;
   localparam ST_TRIP    = 4'b0010;
   localparam ST_ACTIVE  = 4'b0100;
   localparam ST_RELEASE = 4'b1000;

   // Bus state
   reg         wr_pend;
   reg         rd_pend;
   reg  [11:0] wr_addr;
   reg  [11:0] rd_addr;
   reg  [31:0] read_mux;
   wire        accept;

   // Global registers
   reg  [15:0] thr_en;
   reg  [15:0] irq_stat;
   reg  [15:0] irq_en;
   reg  [31:0] meas;
   reg  [15:0] next_irq_stat;

   // Tick, flash and acknowledge
   reg  [31:0] tick_cnt;
   reg         tick;
   reg  [3:0]  flash_cnt;
   reg         flash_phase;
   reg         ack_s1;
   reg         ack_s2;
   reg         ack_s3;
   wire        ack_pulse;

   // Per-channel results
   wire [6:0]   act_vec;
   wire [6:0]   hi_vec;
   wire [6:0]   lo_vec;
   wire [6:0]   unacked_vec;
   wire [6:0]   annun_vec;
   wire [6:0]   rise_vec;
   wire [6:0]   fall_vec;
   wire [48:0]  alloc_flat;
   wire [223:0] ch_rdata;
   reg  [6:0]   next_relay;
   integer      i;

   // Parameter memory ports
   wire        pi_we;
   wire        pi_re;
   wire [31:0] pi_rdata;
   reg  [31:0] pi_wdata;

   wire        wr_ch   = wr_pend && (wr_addr[11:8] == `ASRL_CH_REGION) && (wr_addr[7:5] != `ASRL_BAD_INDEX);
   wire        rd_ch   = (rd_addr[11:8] == `ASRL_CH_REGION) && (rd_addr[7:5] != `ASRL_BAD_INDEX);
   wire        rd_pi   = (rd_addr[11:8] == `ASRL_PI_REGION) && (rd_addr[6:4] != `ASRL_BAD_INDEX)
                         && (rd_addr[7] == 1'b0);
   wire        wr_glob = wr_pend && (wr_addr[11:8] == 4'h0);

   assign accept    = hsel && htrans[1] && hready;
   assign ack_pulse = ack_s2 && !ack_s3;
   assign pi_we     = wr_pend && (wr_addr[11:8] == `ASRL_PI_REGION) && (wr_addr[7] == 1'b0)
                      && (wr_addr[6:4] != `ASRL_BAD_INDEX);
   assign pi_re     = accept && !hwrite && (haddr[11:8] == `ASRL_PI_REGION) && (haddr[7] == 1'b0)
                      && (haddr[6:4] != `ASRL_BAD_INDEX);

   // Address and data phase tracking; reads take one wait state
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend   <= 1'b0;
         rd_pend   <= 1'b0;
         wr_addr   <= 12'h000;
         rd_addr   <= 12'h000;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hresp   <= 1'b0;
         wr_pend <= accept && hwrite;
         rd_pend <= accept && !hwrite;
         if (accept) begin
            if (hwrite) begin
               wr_addr <= haddr[11:0];
            end else begin
               rd_addr <= haddr[11:0];
            end
         end
         if (rd_pend) begin
            hrdata    <= read_mux;
            hreadyout <= 1'b1;
         end else if (accept && !hwrite) begin
            hreadyout <= 1'b0;
         end
      end
   end

   // Read data selection
   always @* begin
      read_mux = 32'h00000000;
      if (rd_addr == `ASRL_THR_EN) begin
         read_mux = {16'h0000, thr_en};
      end else if (rd_addr == `ASRL_STATUS) begin
         read_mux = {1'b0, unacked_vec, 1'b0, lo_vec, 1'b0, hi_vec, 1'b0, act_vec};
      end else if (rd_addr == `ASRL_IRQ_STATUS) begin
         read_mux = {16'h0000, irq_stat};
      end else if (rd_addr == `ASRL_IRQ_ENABLE) begin
         read_mux = {16'h0000, irq_en};
      end else if (rd_addr == `ASRL_RELAY_STATE) begin
         read_mux = {25'h0000000, relay_out};
      end else if (rd_addr == `ASRL_MEAS) begin
         read_mux = meas;
      end else if (rd_ch) begin
         read_mux = ch_rdata[rd_addr[7:5]*32 +: 32];
      end else if (rd_pi) begin
         read_mux = pi_rdata;
      end
   end

   // Gains clamp at the top of their range
   always @* begin
      pi_wdata = hwdata;
      if ((wr_addr[3:2] == `ASRL_PI_PGAIN) || (wr_addr[3:2] == `ASRL_PI_IGAIN)) begin
         if ($signed(hwdata) > $signed(`ASRL_GAIN_MAX)) begin
            pi_wdata = `ASRL_GAIN_MAX;
         end
      end
   end

   asrl_pi_mem u_pi_mem (
      .clk   (hclk),
      .rst_n (hresetn),
      .we    (pi_we),
      .waddr (wr_addr[6:2]),
      .wdata (pi_wdata),
      .re    (pi_re),
      .raddr (haddr[6:2]),
      .rdata (pi_rdata)
   );

   // Global registers, measurement sample and sticky events
   always @* begin
      next_irq_stat = irq_stat;
      if (wr_glob && (wr_addr == `ASRL_IRQ_CLEAR)) begin
         next_irq_stat = irq_stat & ~hwdata[15:0];
      end
      next_irq_stat = next_irq_stat | {1'b0, fall_vec, 1'b0, rise_vec};
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         thr_en   <= `ASRL_THR_EN_RST;
         irq_stat <= 16'h0000;
         irq_en   <= 16'h0000;
         meas     <= 32'h00000000;
         irq      <= 1'b0;
      end else begin
         if (wr_glob && (wr_addr == `ASRL_THR_EN)) begin
            thr_en <= hwdata[15:0] & 16'h7F7F;
         end
         if (wr_glob && (wr_addr == `ASRL_IRQ_ENABLE)) begin
            irq_en <= hwdata[15:0] & 16'h7F7F;
         end
         if (meas_strobe) begin
            meas <= meas_value;
         end
         irq_stat <= next_irq_stat;
         irq      <= |(next_irq_stat & irq_en);
      end
   end

   // Tenth-second tick, flash phase and acknowledge button
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt    <= 32'h00000000;
         tick        <= 1'b0;
         flash_cnt   <= 4'h0;
         flash_phase <= 1'b0;
         ack_s1      <= 1'b0;
         ack_s2      <= 1'b0;
         ack_s3      <= 1'b0;
      end else begin
         ack_s1 <= ack_button;
         ack_s2 <= ack_s1;
         ack_s3 <= ack_s2;
         if (tick_cnt == TICK_CYCLES - 1) begin
            tick_cnt <= 32'h00000000;
            tick     <= 1'b1;
         end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
            tick     <= 1'b0;
         end
         if (tick) begin
            if (flash_cnt == `ASRL_FLASH_TICKS - 4'h1) begin
               flash_cnt   <= 4'h0;
               flash_phase <= !flash_phase;
            end else begin
               flash_cnt <= flash_cnt + 4'h1;
            end
         end
      end
   end

   // Alarm channels
   genvar c;
   generate
      for (c = 0; c < `ASRL_NCH; c = c + 1) begin : g_ch
         reg  [31:0] hi_thr;
         reg  [31:0] lo_thr;
         reg  [31:0] deadband;
         reg  [15:0] trip_delay;
         reg  [15:0] release_delay;
         reg  [6:0]  alloc;
         reg  [3:0]  state;
         reg  [15:0] cnt;
         reg         act_d;
         reg         unacked;
         reg  [31:0] rdata;
         wire        wr_me  = wr_ch && (wr_addr[7:5] == c);
         wire        hi_on  = thr_en[c];
         wire        lo_on  = thr_en[8+c];
         wire        act    = state[2] || state[3];
         wire [15:0] cnt_p1 = cnt + 16'h0001;
         wire signed [33:0] meas_x = {{2{meas[31]}}, meas};
         wire signed [33:0] hi_x   = {{2{hi_thr[31]}}, hi_thr};
         wire signed [33:0] lo_x   = {{2{lo_thr[31]}}, lo_thr};
         wire signed [33:0] db_x   = {2'b00, deadband};
         wire signed [33:0] hi_lim = act ? (hi_x - db_x) : hi_x;
         wire signed [33:0] lo_lim = act ? (lo_x + db_x) : lo_x;
         wire        hi_cond = (meas_x >= hi_lim);
         wire        lo_cond = (meas_x <= lo_lim);
         wire        cond    = (hi_on && lo_on) ? ((hi_x >= lo_x) ? (hi_cond || lo_cond)
                                                                  : (hi_cond && lo_cond))
                             : hi_on ? hi_cond
                             : lo_on ? lo_cond
                             : 1'b0;

         assign act_vec[c]        = act;
         assign hi_vec[c]         = act && hi_on && hi_cond;
         assign lo_vec[c]         = act && lo_on && lo_cond;
         assign unacked_vec[c]    = unacked;
         assign annun_vec[c]      = act && (!unacked || flash_phase);
         assign rise_vec[c]       = act && !act_d;
         assign fall_vec[c]       = !act && act_d;
         assign alloc_flat[c*7 +: 7] = alloc;
         assign ch_rdata[c*32 +: 32] = rdata;

         always @* begin
            case (rd_addr[4:2])
               `ASRL_CH_HIGH:     rdata = hi_thr;
               `ASRL_CH_LOW:      rdata = lo_thr;
               `ASRL_CH_DEADBAND: rdata = deadband;
               `ASRL_CH_TRIP:     rdata = {16'h0000, trip_delay};
               `ASRL_CH_RELEASE:  rdata = {16'h0000, release_delay};
               `ASRL_CH_ALLOC:    rdata = {25'h0000000, alloc};
               default:           rdata = 32'h00000000;
            endcase
         end

         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               hi_thr        <= 32'h00000000;
               lo_thr        <= 32'h00000000;
               deadband      <= `ASRL_DEADBAND_RST;
               trip_delay    <= `ASRL_DELAY_RST;
               release_delay <= `ASRL_DELAY_RST;
               alloc         <= `ASRL_ALLOC_RST << c;
            end else if (wr_me) begin
               case (wr_addr[4:2])
                  `ASRL_CH_HIGH: hi_thr <= hwdata;
                  `ASRL_CH_LOW:  lo_thr <= hwdata;
                  `ASRL_CH_DEADBAND: begin
                     deadband <= (hwdata > `ASRL_DEADBAND_MAX) ? `ASRL_DEADBAND_MAX : hwdata;
                  end
                  `ASRL_CH_TRIP: begin
                     trip_delay <= (hwdata > {16'h0000, `ASRL_DELAY_MAX}) ? `ASRL_DELAY_MAX : hwdata[15:0];
                  end
                  `ASRL_CH_RELEASE: begin
                     release_delay <= (hwdata > {16'h0000, `ASRL_DELAY_MAX}) ? `ASRL_DELAY_MAX : hwdata[15:0];
                  end
                  `ASRL_CH_ALLOC: alloc <= hwdata[6:0];
                  default: alloc <= alloc;
               endcase
            end
         end

         // Trip and release timing
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               state   <= ST_IDLE;
               cnt     <= 16'h0000;
               act_d   <= 1'b0;
               unacked <= 1'b0;
            end else begin
               act_d <= act;
               if (act && !act_d) begin
                  unacked <= 1'b1;
               end else if (ack_pulse || !act) begin
                  unacked <= 1'b0;
               end
               case (state)
                  ST_IDLE: begin
                     if (cond) begin
                        cnt   <= 16'h0000;
                        state <= (trip_delay == 16'h0000) ? ST_ACTIVE : ST_TRIP;
                     end
                  end
                  ST_TRIP: begin
                     if (!cond) begin
                        state <= ST_IDLE;
                     end else if (tick) begin
                        if (cnt_p1 >= trip_delay) begin
                           state <= ST_ACTIVE;
                        end else begin
                           cnt <= cnt_p1;
                        end
                     end
                  end
                  ST_ACTIVE: begin
                     if (!cond) begin
                        cnt   <= 16'h0000;
                        state <= (release_delay == 16'h0000) ? ST_IDLE : ST_RELEASE;
                     end
                  end
                  ST_RELEASE: begin
                     if (cond) begin
                        state <= ST_ACTIVE;
                     end else if (tick) begin
                        if (cnt_p1 >= release_delay) begin
                           state <= ST_IDLE;
                        end else begin
                           cnt <= cnt_p1;
                        end
                     end
                  end
                  default: state <= ST_IDLE;
               endcase
            end
         end
      end
   endgenerate

   // Relays follow every channel allocated to them
   always @* begin
      next_relay = 7'h00;
      for (i = 0; i < `ASRL_NCH; i = i + 1) begin
         next_relay = next_relay | (alloc_flat[i*7 +: 7] & {7{act_vec[i]}});
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         relay_out   <= 7'h00;
         annunciator <= 7'h00;
      end else begin
         relay_out   <= next_relay;
         annunciator <= annun_vec;
      end
   end

endmodule

// ==== verification/asrl_props.sv ====
// Port checker of the alarm setpoint relay block.
// Assumes one AHB-Lite master on hclk with hready fed back from hreadyout.
`timescale 1ns/1ps
module asrl_props #(
   parameter TICK_CYCLES = 10
) (
   // Clock and reset
   input wire        hclk,
   input wire        hresetn,
   // Bus
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   // Outputs
   input wire [6:0]  annunciator,
   input wire [6:0]  relay_out,
   input wire        irq
);
   reg        dph;
   reg [11:0] da;
   reg [13:0] ien;
   reg        armed;
   wire       take = hsel && htrans[1] && hready;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Shadow of the enable registers, tracked from bus writes
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph <= 1'b0;
         da <= 12'h000;
         ien <= 14'h0000;
         armed <= 1'b0;
      end else begin
         dph <= take && hwrite;
         da <= haddr[11:0];
         if (dph && da == 12'h010)
            ien <= {hwdata[14:8], hwdata[6:0]};
         if (dph && da == 12'h000 && |{hwdata[14:8], hwdata[6:0]})
            armed <= 1'b1;
      end
   end

   sequence s_read;
      take && !hwrite;
   endsequence
   sequence s_one_wait;
      !hreadyout ##1 hreadyout;
   endsequence

   chk_read_wait: assert property (s_read |=> s_one_wait)
      else $error("read data phase not one wait state");
   chk_write_ready: assert property (take && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   chk_single_wait: assert property (!hreadyout |=> hreadyout)
      else $error("wait state longer than one cycle");
   chk_resp_okay: assert property (!hresp)
      else $error("response not okay");
   chk_rdata_hold: assert property ($past(hreadyout) && hreadyout |-> $stable(hrdata))
      else $error("read data changed outside a read");
   chk_reset_quiet: assert property ($rose(hresetn) |-> relay_out == 7'h00 && annunciator == 7'h00 && !irq)
      else $error("outputs active after reset");
   chk_alarm_quiet: assert property (!armed |-> relay_out == 7'h00 && annunciator == 7'h00)
      else $error("alarm with all thresholds off");
   chk_irq_masked: assert property (ien == 14'h0000 |=> !irq)
      else $error("interrupt with nothing enabled");
endmodule

bind asrl_top asrl_props #(.TICK_CYCLES(TICK_CYCLES)) i_asrl_props (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .annunciator(annunciator),
   .relay_out(relay_out), .irq(irq));

// ==== verification/asrl_panel.sv ====
// Front panel model: acknowledge button and relay watcher.
// Assumes presses are requested by the bench through the press task.
`timescale 1ns/1ps
module asrl_panel (
   // Clock
   input  wire       hclk,
   // Panel lines
   input  wire [6:0] relay_out,
   output reg        ack_button,
   // Relays ever energised
   output reg  [6:0] relay_seen
);
   initial ack_button = 1'b0;
   initial relay_seen = 7'h00;

   always @(posedge hclk)
      relay_seen <= relay_seen | relay_out;

   // Held for several cycles so the synchroniser sees one clean edge
   task press;
      begin
         @(posedge hclk);
         ack_button <= 1'b1;
         repeat (4) @(posedge hclk);
         ack_button <= 1'b0;
      end
   endtask
endmodule

// ==== verification/alarm_setpoint_relay_logic_tb.sv ====
// Self-checking bench of the alarm setpoint relay block.
// Assumes the design on a 25 ns hclk with TICK_CYCLES shortened to 10.
`timescale 1ns/1ps
module alarm_setpoint_relay_logic_tb;
   reg         hclk = 1'b0;
   reg         hresetn = 1'b0;
   reg         hsel = 1'b0;
   reg  [31:0] haddr = 32'h0;
   reg  [1:0]  htrans = 2'h0;
   reg         hwrite = 1'b0;
   reg  [31:0] hwdata = 32'h0;
   reg  [31:0] meas_value = 32'h0;
   reg         meas_strobe = 1'b0;
   wire [31:0] hrdata;
   wire        hreadyout;
   wire        hresp;
   wire        ack_button;
   wire [6:0]  annunciator;
   wire [6:0]  relay_out;
   wire [6:0]  relay_seen;
   wire        irq;
   integer     error_cnt = 0;
   integer     checks = 0;
   integer     i;
   integer     n;
   reg  [31:0] rv;

   always #12.5 hclk = ~hclk;

   asrl_top #(.TICK_CYCLES(10)) i_asrl_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .meas_value(meas_value),
      .meas_strobe(meas_strobe), .ack_button(ack_button), .annunciator(annunciator),
      .relay_out(relay_out), .irq(irq));
   asrl_panel i_asrl_panel (.hclk(hclk), .relay_out(relay_out), .ack_button(ack_button),
      .relay_seen(relay_seen));

   task final_report;
      begin
         if (error_cnt == 0 && checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   task cmp(input string nm, input [31:0] e, input [31:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask

   task rdy;
      reg r;
      begin
         r = 1'b0;
         while (r !== 1'b1) begin
            @(negedge hclk);
            r = hreadyout;
            rv = hrdata;
            @(posedge hclk);
         end
      end
   endtask

   task bus(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge hclk);
         hsel <= 1'b1;
         haddr <= {20'h00000, a};
         hwrite <= w;
         htrans <= 2'h2;
         rdy;
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
         rdy;
      end
   endtask

   task wr(input [11:0] a, input [31:0] d);
      bus(1'b1, a, d);
   endtask

   task rdc(input string nm, input [11:0] a, input [31:0] e);
      begin
         bus(1'b0, a, 32'h0);
         cmp(nm, e, rv);
      end
   endtask

   function [11:0] ca(input [2:0] c, input [11:0] o);
      ca = {4'h1, c, 5'h00} + o;
   endfunction

   function [11:0] pa(input [2:0] r, input [11:0] o);
      pa = {4'h2, 1'b0, r, 4'h0} + o;
   endfunction

   task meas(input [31:0] v);
      begin
         @(posedge hclk);
         meas_value <= v;
         meas_strobe <= 1'b1;
         @(posedge hclk);
         meas_strobe <= 1'b0;
         repeat (3) @(posedge hclk);
      end
   endtask

   task mr(input [31:0] v, input [6:0] e);
      begin
         meas(v);
         cmp("relay_out", {25'h0, e}, {25'h0, relay_out});
      end
   endtask

   task wt(input [6:0] e, input integer lim);
      begin
         n = 0;
         while (relay_out !== e && n < lim) begin
            @(negedge hclk);
            n = n + 1;
         end
         cmp("relay_out", {25'h0, e}, {25'h0, relay_out});
      end
   endtask

   task lit;
      begin
         n = 0;
         repeat (120) begin
            @(negedge hclk);
            if (annunciator[4] === 1'b1)
               n = n + 1;
         end
      end
   endtask

   task t_defaults;
      begin
         rdc("thr_en", 12'h000, 32'h0);
         for (i = 0; i < 7; i = i + 1) begin
            rdc("deadband", ca(i, 12'h008), 32'h0000000A);
            rdc("trip", ca(i, 12'h00C), 32'h0);
            rdc("release", ca(i, 12'h010), 32'h0);
            rdc("alloc", ca(i, 12'h014), 32'h1 << i);
            rdc("span", pa(i, 12'h000), 32'h00000064);
            rdc("target", pa(i, 12'h004), 32'h000003E8);
            rdc("pgain", pa(i, 12'h008), 32'h0000000A);
            rdc("igain", pa(i, 12'h00C), 32'h0);
         end
         wr(pa(2, 12'h008), 32'h00009C40);
         rdc("pgain", pa(2, 12'h008), 32'h00007FFF);
         rdc("unmapped", 12'hFFC, 32'h0);
      end
   endtask

   task t_high;
      begin
         wr(ca(0, 12'h000), 32'h64);
         wr(ca(0, 12'h014), 32'h41);
         wr(12'h000, 32'h1);
         mr(32'h63, 7'h00);
         mr(32'h64, 7'h41);
         mr(32'h5A, 7'h41);
         mr(32'h59, 7'h00);
         cmp("relay_seen", 32'h41, {25'h0, relay_seen});
         wr(12'h000, 32'h0);
      end
   endtask

   task t_low;
      begin
         wr(ca(1, 12'h008), 32'h0000EA60);
         rdc("deadband", ca(1, 12'h008), 32'h0000C350);
         wr(ca(1, 12'h008), 32'h00000005);
         wr(ca(1, 12'h004), 32'h00000014);
         wr(12'h000, 32'h00000200);
         mr(32'h00000015, 7'h00);
         mr(32'h00000014, 7'h02);
         mr(32'h00000019, 7'h02);
         mr(32'h0000001A, 7'h00);
         wr(12'h000, 32'h0);
      end
   endtask

   task t_band;
      begin
         wr(ca(2, 12'h008), 32'h0);
         wr(ca(2, 12'h000), 32'h32);
         wr(ca(2, 12'h004), 32'hA);
         wr(12'h000, 32'h404);
         mr(32'h1E, 7'h00);
         mr(32'h33, 7'h04);
         mr(32'h1E, 7'h00);
         mr(32'hA, 7'h04);
         wr(ca(2, 12'h000), 32'hA);
         wr(ca(2, 12'h004), 32'h32);
         mr(32'h1E, 7'h04);
         mr(32'h3C, 7'h00);
         mr(32'h1E, 7'h04);
         wr(12'h000, 32'h0);
         mr(32'h1E, 7'h00);
      end
   endtask

   task t_delay;
      begin
         wr(ca(3, 12'h000), 32'h64);
         wr(ca(3, 12'h00C), 32'h3);
         wr(ca(3, 12'h010), 32'h3);
         wr(12'h000, 32'h8);
         meas(32'h64);
         repeat (12) @(posedge hclk);
         mr(32'h0, 7'h00);
         meas(32'h64);
         repeat (12) @(negedge hclk);
         cmp("relay_out", 32'h0, {25'h0, relay_out});
         wt(7'h08, 40);
         meas(32'h0);
         repeat (12) @(negedge hclk);
         cmp("relay_out", 32'h8, {25'h0, relay_out});
         meas(32'h64);
         meas(32'h0);
         repeat (12) @(negedge hclk);
         cmp("relay_out", 32'h8, {25'h0, relay_out});
         wt(7'h00, 40);
         wr(12'h000, 32'h0);
      end
   endtask

   task t_ann;
      begin
         wr(12'h00C, 32'h7F7F);
         wr(ca(4, 12'h000), 32'h0);
         wr(12'h010, 32'h00000010);
         wr(12'h000, 32'h00000010);
         meas(32'h00000005);
         repeat (3) @(negedge hclk);
         cmp("irq", 32'h1, {31'h0, irq});
         lit;
         cmp("flashing", 32'h1, {31'h0, n > 0 && n < 120});
         i_asrl_panel.press;
         repeat (8) @(posedge hclk);
         lit;
         cmp("steady", 32'd120, n);
         rdc("irq_status", 12'h008, 32'h00000010);
         wr(12'h00C, 32'h00000010);
         repeat (3) @(negedge hclk);
         cmp("irq", 32'h0, {31'h0, irq});
         meas(32'hFFFFFF9C);
         repeat (3) @(negedge hclk);
         cmp("annunciator", 32'h0, {25'h0, annunciator});
         cmp("irq", 32'h0, {31'h0, irq});
         rdc("irq_status", 12'h008, 32'h00001000);
      end
   endtask

   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_defaults;
      t_high;
      t_low;
      t_band;
      t_delay;
      t_ann;
      final_report;
   end

   initial begin
      repeat (20000) @(posedge hclk);
      error_cnt = error_cnt + 1;
      final_report;
   end
endmodule
